// [logic/meter_pkg.sv]
// Constants and types for the paired counter frequency and period meter
package meter_pkg;
  localparam int COUNT_WIDTH = 24;
  localparam int CLOCK_HZ = 40000000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 24'h000000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 24'hffffff;
  localparam logic [COUNT_WIDTH-1:0] DIVISOR_RESET = 24'h000001;
  localparam logic [COUNT_WIDTH-1:0] GATE_TIME_RESET = 24'h009c40;
  localparam logic [COUNT_WIDTH-1:0] MIN_VALID_COUNT = 24'h000002;
  typedef logic [COUNT_WIDTH-1:0] count_t;
  typedef enum logic {
    METHOD_HIGH_FREQ,
    METHOD_LARGE_RANGE
  } method_t;
endpackage : meter_pkg

// [logic/pair_if.sv]
// Dedicated links between the two counters of one pair
`timescale 1ns/1ps
`default_nettype none
interface pair_if;
  import meter_pkg::*;
  logic gate;
  logic input_edge;
  logic partner_enable;
  logic measure_restart;
  modport partner (output gate, input input_edge, input partner_enable, input measure_restart);
  modport measure (input gate, output input_edge, output partner_enable, output measure_restart);
endinterface : pair_if
`default_nettype wire

// [logic/partner_counter.sv]
// Partner counter: gate pulse train or input divider
`timescale 1ns/1ps
`default_nettype none
module partner_counter
  import meter_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire meter_pkg::method_t method,
  input wire meter_pkg::count_t gate_ticks,
  input wire meter_pkg::count_t divisor,
  pair_if.partner link
);
  import meter_pkg::*;
  count_t count_reg;
  count_t count_next;
  logic gate_reg;
  logic gate_next;
  count_t limit;

  always_comb
  begin
    // A zero setting behaves as one to keep the period finite
    if (method == METHOD_HIGH_FREQ)
      limit = (gate_ticks == COUNT_RESET) ? DIVISOR_RESET : gate_ticks;
    else
      limit = (divisor == COUNT_RESET) ? DIVISOR_RESET : divisor;
    count_next = count_reg;
    gate_next = 1'b0;
    if (!link.partner_enable || link.measure_restart)
      count_next = COUNT_RESET;
    else if (method == METHOD_HIGH_FREQ)
    begin
      // One pulse per measurement time
      if (count_reg >= limit - DIVISOR_RESET)
      begin
        count_next = COUNT_RESET;
        gate_next = 1'b1;
      end
      else
        count_next = count_reg + DIVISOR_RESET;
    end
    else if (link.input_edge)
    begin
      // One pulse per divisor input edges
      if (count_reg >= limit - DIVISOR_RESET)
      begin
        count_next = COUNT_RESET;
        gate_next = 1'b1;
      end
      else
        count_next = count_reg + DIVISOR_RESET;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_reg <= COUNT_RESET;
      gate_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      gate_reg <= gate_next;
    end
  end

  assign link.gate = gate_reg;
endmodule : partner_counter
`default_nettype wire

// [logic/paired_counter_freq_period_meter.sv]
// Paired counter meter: measuring counter with its partner
// Operation
// - Counters pair even with next odd, linked both ways.
// - High-frequency: partner emits a pulse each measurement time as gate.
// - High-frequency: measuring counter counts input periods per gate, averages, reports.
// - High-frequency: period = time / count; frequency = count / time.
// - Large-range: partner divides input by divisor; measuring counter times it.
// - Large-range: period = measured divided period / divisor.
// - 24-bit count; large-range valid counts 2 up to 2^24 - 1.
// - Input is sampled by the timebase, so it works only up to half the timebase rate.
// - Asynchronous phase gives count plus or minus one.
// - Larger divisor or timebase lowers quantization error.
`timescale 1ns/1ps
`default_nettype none
module paired_counter_freq_period_meter
  import meter_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire meter_pkg::method_t method,
  input wire meter_pkg::count_t gate_ticks,
  input wire meter_pkg::count_t divisor,
  input wire logic [2:0] average_shift,
  input wire logic signal_in,
  input wire logic overflow_clear,
  output logic [meter_pkg::COUNT_WIDTH-1:0] result,
  output logic [meter_pkg::COUNT_WIDTH-1:0] raw_count,
  output logic result_valid,
  output logic sample_valid,
  output logic overflow
);
  import meter_pkg::*;

  // Pair link between the measuring counter and its partner
  pair_if link ();

  partner_counter partner (
    .clock(clock),
    .reset_n(reset_n),
    .method(method),
    .gate_ticks(gate_ticks),
    .divisor(divisor),
    .link(link)
  );

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic enable_reg;
  logic edge_now;

  // Two stages before use; the timebase sees each rising input edge once
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      enable_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= signal_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      enable_reg <= enable;
    end
  end

  // The third stage serves only the edge detector
  assign edge_now = sync2_reg & ~sync3_reg;
  assign link.input_edge = edge_now;
  // Settings are read live, so they should change only while enable is low
  assign link.partner_enable = enable;
  assign link.measure_restart = enable & ~enable_reg;

  // Measuring counter and its averaging state
  count_t count_reg;
  count_t count_next;
  logic wrap_reg;
  logic wrap_next;
  logic armed_reg;
  logic armed_next;
  // Seven spare bits hold 128 full-scale samples without wrapping
  logic [COUNT_WIDTH+6:0] acc_reg;
  logic [COUNT_WIDTH+6:0] acc_next;
  logic [COUNT_WIDTH+6:0] acc_sum;
  logic [7:0] nacc_reg;
  logic [7:0] nacc_next;
  count_t result_reg;
  count_t result_next;
  count_t raw_reg;
  count_t raw_next;
  logic result_valid_reg;
  logic result_valid_next;
  logic sample_valid_reg;
  logic sample_valid_next;
  logic overflow_reg;
  logic overflow_next;
  // One to 128 samples per result
  logic [7:0] nacc_target;
  logic tick;
  logic wrap_now;
  logic good;
  logic range_ok;

  always_comb
  begin
    nacc_target = 8'h01 << average_shift;
    // High-frequency counts input edges, large-range counts timebase ticks
    tick = (method == METHOD_HIGH_FREQ) ? edge_now : 1'b1;
    wrap_now = tick && (count_reg == COUNT_MAX);
    acc_sum = acc_reg + {7'h00, count_reg};
    // Large-range counts under two ticks lie outside the valid range
    range_ok = (method == METHOD_HIGH_FREQ) || (count_reg >= MIN_VALID_COUNT);
    count_next = count_reg;
    wrap_next = wrap_reg;
    armed_next = armed_reg;
    acc_next = acc_reg;
    nacc_next = nacc_reg;
    result_next = result_reg;
    raw_next = raw_reg;
    result_valid_next = 1'b0;
    sample_valid_next = sample_valid_reg;
    good = 1'b0;
    // Set wins over a clear arriving in the same cycle
    overflow_next = overflow_reg & ~overflow_clear;
    // Restart drops any partial window so old and new settings never mix
    if (!enable || link.measure_restart)
    begin
      count_next = COUNT_RESET;
      wrap_next = 1'b0;
      armed_next = 1'b0;
      acc_next = '0;
      nacc_next = 8'h00;
    end
    else if (link.gate)
    begin
      // Window closes; the first gate only opens the window
      // An input edge on the gate cycle counts as the first of the next window
      count_next = tick ? DIVISOR_RESET : COUNT_RESET;
      wrap_next = 1'b0;
      armed_next = 1'b1;
      if (armed_reg)
      begin
        raw_next = count_reg;
        // Rollover or under-range count spoils the sample
        good = !wrap_reg && range_ok;
        sample_valid_next = good;
        if (wrap_reg)
          overflow_next = 1'b1;
        if (good)
        begin
          // Sum of samples; for large-range the divided period stands
          acc_next = acc_sum;
          nacc_next = nacc_reg + 8'h01;
          if (nacc_reg + 8'h01 == nacc_target)
          begin
            // Mean via shift; the host applies time or divisor scaling
            result_next = count_t'(acc_sum >> average_shift);
            result_valid_next = 1'b1;
            acc_next = '0;
            nacc_next = 8'h00;
          end
        end
      end
    end
    else if (tick)
    begin
      count_next = count_reg + DIVISOR_RESET;
      // A wrap spoils the current window and latches the flag
      if (wrap_now)
      begin
        wrap_next = 1'b1;
        overflow_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_reg <= COUNT_RESET;
      wrap_reg <= 1'b0;
      armed_reg <= 1'b0;
      acc_reg <= '0;
      nacc_reg <= 8'h00;
      result_reg <= COUNT_RESET;
      raw_reg <= COUNT_RESET;
      result_valid_reg <= 1'b0;
      sample_valid_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      wrap_reg <= wrap_next;
      armed_reg <= armed_next;
      acc_reg <= acc_next;
      nacc_reg <= nacc_next;
      result_reg <= result_next;
      raw_reg <= raw_next;
      result_valid_reg <= result_valid_next;
      sample_valid_reg <= sample_valid_next;
      overflow_reg <= overflow_next;
    end
  end

  // Outputs come straight from registers
  assign result = result_reg;
  assign raw_count = raw_reg;
  assign result_valid = result_valid_reg;
  assign sample_valid = sample_valid_reg;
  assign overflow = overflow_reg;
endmodule : paired_counter_freq_period_meter
`default_nettype wire

// [test/meter_assertions.sv]
// Port checker for the paired counter meter
`timescale 1ns/1ps
`default_nettype none
module meter_assertions
  import meter_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire meter_pkg::method_t method,
  input wire meter_pkg::count_t gate_ticks,
  input wire logic [2:0] average_shift,
  input wire logic overflow_clear,
  input wire logic [meter_pkg::COUNT_WIDTH-1:0] result,
  input wire logic [meter_pkg::COUNT_WIDTH-1:0] raw_count,
  input wire logic result_valid,
  input wire logic sample_valid,
  input wire logic overflow
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ovf_hold; overflow && !overflow_clear |=> overflow; endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow dropped");
  property p_ovf_clr; $fell(overflow) |-> $past(overflow_clear); endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow fell uncleared");
  property p_idle; !enable [*3] |-> !result_valid; endproperty
  a_idle: assert property (p_idle) else $error("result while idle");
  property p_good; result_valid |-> sample_valid; endproperty
  a_good: assert property (p_good) else $error("result from bad sample");
  property p_avg1; result_valid && average_shift == 3'h0 |-> result == raw_count; endproperty
  a_avg1: assert property (p_avg1) else $error("single average differs");
  property p_min; sample_valid && method == METHOD_LARGE_RANGE |-> raw_count >= MIN_VALID_COUNT;
  endproperty
  a_min: assert property (p_min) else $error("valid count below two");
  property p_hold; result_valid ##1 enable |-> $stable(result); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_arm;
    $rose(enable) && method == METHOD_HIGH_FREQ && gate_ticks > 24'h000008 |=> !result_valid [*8];
  endproperty
  a_arm: assert property (p_arm) else $error("first gate not arming");
endmodule : meter_assertions
bind paired_counter_freq_period_meter meter_assertions meter_assertions_i (.*);
`default_nettype wire

// [test/signal_source.sv]
// Free-running square wave standing in for the measured input
`timescale 1ns/1ps
`default_nettype none
module signal_source (
  input var int half_ns,
  output logic sig
);
  // Odd start offset keeps edges off the clock phase
  initial
  begin
    sig = 1'b0;
    #7;
    forever
    begin
      #(half_ns) sig = ~sig;
    end
  end
endmodule : signal_source
`default_nettype wire

// [test/paired_counter_freq_period_meter_bench.sv]
// Self-checking bench for the paired counter meter
`timescale 1ns/1ps
`default_nettype none
module paired_counter_freq_period_meter_bench;
  import meter_pkg::*;
  typedef struct {method_t m; count_t gate; count_t div; logic [2:0] shift; int half;
    count_t exp;} row_t;
  // Short windows and small divisors keep counts far from wrapping
  // HF expected: gate clocks x 25 ns / input period, periods per window
  // LR expected: input period x divisor / 25 ns, ticks per divided period
  row_t rows[5] = '{
    '{METHOD_HIGH_FREQ, 24'h000190, 24'h000001, 3'h0, 250, 24'h000014},
    '{METHOD_HIGH_FREQ, 24'h0003e8, 24'h000001, 3'h2, 500, 24'h000019},
    '{METHOD_LARGE_RANGE, 24'h000001, 24'h000004, 3'h0, 250, 24'h000050},
    '{METHOD_LARGE_RANGE, 24'h000001, 24'h000001, 3'h1, 50, 24'h000004},
    '{METHOD_LARGE_RANGE, 24'h000001, 24'h000003, 3'h0, 25, 24'h000006}};
  logic clock, reset_n, enable, overflow_clear, signal_in;
  method_t method;
  count_t gate_ticks, divisor;
  logic [2:0] average_shift;
  logic [23:0] result, raw_count;
  logic result_valid, sample_valid, overflow;
  int half_ns, num_errors, n_checks, hits;
  paired_counter_freq_period_meter paired_counter_freq_period_meter_i (.clock(clock),
    .reset_n(reset_n), .enable(enable), .method(method), .gate_ticks(gate_ticks),
    .divisor(divisor), .average_shift(average_shift), .signal_in(signal_in),
    .overflow_clear(overflow_clear), .result(result), .raw_count(raw_count),
    .result_valid(result_valid), .sample_valid(sample_valid), .overflow(overflow));
  signal_source signal_source_i (.half_ns(half_ns), .sig(signal_in));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Slack allows the one-count phase uncertainty
  task check(input logic [23:0] got, input logic [23:0] exp, input logic slack);
    n_checks++;
    if (!(got === exp || slack && (got === exp + 24'h1 || got === exp - 24'h1)))
    begin
      num_errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task wait_valid;
    int i;
    i = 0;
    @(posedge clock);
    #1;
    while (result_valid !== 1'b1 && i < 30000)
    begin
      @(posedge clock);
      #1;
      i++;
    end
    if (i == 30000)
    begin
      num_errors++;
      wrap_up();
    end
  endtask : wait_valid
  initial
  begin
    reset_n = 1'b0;
    enable = 1'b0;
    overflow_clear = 1'b0;
    method = METHOD_HIGH_FREQ;
    gate_ticks = 24'h000010;
    divisor = 24'h000001;
    average_shift = 3'h0;
    half_ns = 250;
    repeat (15) @(posedge clock);
    #1;
    check(result, 24'h000000, 1'b0);
    check(raw_count, 24'h000000, 1'b0);
    check(24'({result_valid, sample_valid, overflow}), 24'h000000, 1'b0);
    @(posedge clock);
    reset_n <= 1'b1;
    foreach (rows[k])
    begin
      @(posedge clock);
      enable <= 1'b0;
      method <= rows[k].m;
      gate_ticks <= rows[k].gate;
      divisor <= rows[k].div;
      average_shift <= rows[k].shift;
      half_ns <= rows[k].half;
      repeat (4) @(posedge clock);
      enable <= 1'b1;
      wait_valid();
      wait_valid();
      check(result, rows[k].exp, 1'b1);
      check(24'(sample_valid), 24'h000001, 1'b0);
      check(24'(overflow), 24'h000000, 1'b0);
      $display("row %0d done", k);
    end
    @(posedge clock);
    overflow_clear <= 1'b1;
    @(posedge clock);
    overflow_clear <= 1'b0;
    enable <= 1'b0;
    // Look at every cycle: a one-cycle pulse slips past a single look
    hits = 0;
    repeat (40)
    begin
      @(posedge clock);
      #1;
      if (result_valid !== 1'b0)
        hits++;
    end
    check(24'(hits), 24'h000000, 1'b0);
    $display("idle test done");
    @(posedge clock);
    enable <= 1'b1;
    repeat (50) @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    #1;
    check(raw_count, 24'h000000, 1'b0);
    check(24'({sample_valid, result_valid}), 24'h000000, 1'b0);
    @(posedge clock);
    reset_n <= 1'b1;
    // Nothing may show at the first two edges after release
    repeat (2)
    begin
      @(posedge clock);
      #1;
      check(result, 24'h000000, 1'b0);
      check(raw_count, 24'h000000, 1'b0);
      check(24'({sample_valid, result_valid, overflow}), 24'h000000, 1'b0);
    end
    // Enable stayed high through reset, so measuring resumes by itself
    wait_valid();
    wait_valid();
    check(result, rows[4].exp, 1'b1);
    check(24'(sample_valid), 24'h000001, 1'b0);
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule : paired_counter_freq_period_meter_bench
`default_nettype wire
